// ===== dv/anps_monitor.sv
// checker of the partner status register bank ports
`timescale 1ns/1ps
`default_nettype none
`include "anps_consts.vh"
module anps_monitor
(
   input wire        clk_i,
   input wire        rst_i,
   input wire        cyc_i,
   input wire        stb_i,
   input wire        we_i,
   input wire [7:0]  adr_i,
   input wire [31:0] dat_i,
   input wire [3:0]  sel_i,
   input wire [31:0] dat_o,
   input wire        ack_o,
   input wire [15:0] code_word_i,
   input wire        code_word_valid_i,
   input wire        autoneg_restart_i,
   input wire        parallel_fault_i,
   input wire        new_page_i,
   input wire        irq_o
);
   reg  [15:0] word;
   reg         seen;
   reg         parallel_detect_fault;
   reg         pg;
   wire [5:0]  idx   = adr_i[7:2];
   wire        take6 = cyc_i & stb_i & ~ack_o & ~we_i & (idx == `ANPS_IDX_EXPANSION);
   wire        rd5   = ack_o & ~we_i & (idx == `ANPS_IDX_PARTNER);
   wire        rd6   = ack_o & ~we_i & (idx == `ANPS_IDX_EXPANSION);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // shadow of the captured word and the latched flags
   always @(posedge clk_i)
   begin
      word <= rst_i ? 16'h0000
            : code_word_valid_i ? code_word_i
            : autoneg_restart_i ? 16'h0000 : word;
      seen <= ~rst_i & (code_word_valid_i | (seen & ~autoneg_restart_i));
      parallel_detect_fault  <= ~rst_i & (parallel_fault_i | (parallel_detect_fault & ~take6));
      pg   <= ~rst_i & (new_page_i | (pg & ~take6));
   end
   ack_answer_a: assert property (cyc_i & stb_i & ~ack_o |=> ack_o)
      else $error("request not acknowledged");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   ability_mirror_a: assert property (rd5 |->
      dat_o == {16'h0, $past(word) & 16'he7ff})
      else $error("partner ability read wrong");
   partner_np_a: assert property (rd6 |-> dat_o[3] == $past(word[15]))
      else $error("partner next page bit wrong");
   local_np_a: assert property (rd6 |-> !dat_o[2])
      else $error("local next page bit set");
   an_seen_a: assert property (rd6 |-> dat_o[0] == $past(seen))
      else $error("autoneg capable bit wrong");
   fault_latch_a: assert property (rd6 |-> dat_o[4] == $past(parallel_detect_fault))
      else $error("parallel fault flag wrong");
   page_latch_a: assert property (rd6 |-> dat_o[1] == $past(pg))
      else $error("new page flag wrong");
   cover property (rd6 && dat_o[4]);
   cover property (rd6 && dat_o[1]);
   cover property (irq_o);
endmodule
`default_nettype wire

// ===== dv/link_partner_model.sv
// link partner model driving code words and event lines
`timescale 1ns/1ps
`default_nettype none
module link_partner_model
(
   input  wire logic   clk_i,
   output logic [15:0] word_o,
   output logic        valid_o,
   output logic [2:0]  ev_o
);
   // idle: word line shows garbage, no pulses
   initial
   begin
      word_o = 16'h5a5a;
      valid_o = 1'b0;
      ev_o = 3'h0;
   end
   // one received base word, then the line is no longer held
   task send(input [15:0] w);
      begin
         @(posedge clk_i);
         word_o <= w;
         valid_o <= 1'b1;
         @(posedge clk_i);
         word_o <= ~w;
         valid_o <= 1'b0;
      end
   endtask
   // one-cycle pulse of restart, fault, page
   task event_pulse(input [2:0] e);
      begin
         @(posedge clk_i);
         ev_o <= e;
         @(posedge clk_i);
         ev_o <= 3'h0;
      end
   endtask
endmodule
`default_nettype wire

// ===== dv/tb_autoneg_partner_status.sv
// self-checking bench of the partner status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_autoneg_partner_status;
   reg         clk_i;
   reg         rst_i;
   reg         cyc;
   reg         stb;
   reg         we;
   reg  [7:0]  adr;
   reg  [31:0] dat;
   reg  [31:0] q;
   reg  [3:0]  sel;
   wire [31:0] dat_o;
   wire        ack_o;
   wire        irq_o;
   wire        valid;
   wire [15:0] word;
   wire [2:0]  ev;
   integer     err_count;
   integer     checks;
   integer     cyc_n;
   integer     i;
   autoneg_partner_status i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o),
      .code_word_i(word), .code_word_valid_i(valid), .autoneg_restart_i(ev[0]),
      .parallel_fault_i(ev[1]), .new_page_i(ev[2]), .irq_o(irq_o));
   link_partner_model i_lp (.clk_i(clk_i), .word_o(word), .valid_o(valid), .ev_o(ev));
   always #25 clk_i = ~clk_i;
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", checks, err_count);
         if (err_count == 0 && checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // cycle ceiling
   always @(posedge clk_i)
   begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 2000)
      begin
         err_count = err_count + 1;
         end_sim;
      end
   end
   task chk(input [31:0] e, input [31:0] g, input string s);
      begin
         checks = checks + 1;
         if (g !== e)
         begin
            $display("mismatch %s expected %h seen %h", s, e, g);
            err_count = err_count + 1;
         end
      end
   endtask
   // classic wishbone cycle, held until ack
   task wb(input [7:0] a, input w, input [31:0] d);
      begin
         @(posedge clk_i);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         dat <= d;
         sel <= 4'h1;
         @(posedge clk_i);
         // ack ends this wait; without ack only the cycle ceiling ends it
         while (ack_o !== 1'b1)
            @(posedge clk_i);
         q = dat_o;
         cyc <= 1'b0;
         stb <= 1'b0;
         we <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e, input string s);
      begin
         wb(a, 1'b0, 32'h0);
         chk(e, q, s);
      end
   endtask
   initial
   begin
      {clk_i, cyc, stb, we, adr, dat, sel} = 0;
      rst_i = 1'b1;
      err_count = 0;
      checks = 0;
      cyc_n = 0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h14, 32'h0, "ability");
      rd(8'h18, 32'h0, "expansion");
      rd(8'h3c, 32'h0, "unmapped");
      $display("test reset done");
      // one advertised bit at a time
      for (i = 0; i < 16; i = i + 1)
      begin
         i_lp.send(16'h0001 << i);
         rd(8'h14, (32'h1 << i) & 32'he7ff, "ability");
         rd(8'h18, {28'h0, i == 15, 3'h1}, "expansion");
      end
      wb(8'h14, 1'b1, 32'h0000_e7ff);
      wb(8'h18, 1'b1, 32'h0000_001f);
      rd(8'h14, 32'h8000, "ability");
      i_lp.event_pulse(3'h1);
      rd(8'h14, 32'h0, "ability");
      rd(8'h18, 32'h0, "expansion");
      $display("test ability done");
      // latched flags and interrupt
      wb(8'h20, 1'b1, 32'h7);
      i_lp.event_pulse(3'h6);
      wb(8'h24, 1'b1, 32'h0);
      chk(32'h0, {31'h0, irq_o}, "irq");
      wb(8'h24, 1'b1, 32'h3);
      chk(32'h1, {31'h0, irq_o}, "irq");
      rd(8'h20, 32'h3, "status");
      rd(8'h18, 32'h12, "expansion");
      rd(8'h18, 32'h0, "expansion");
      wb(8'h20, 1'b1, 32'h1);
      chk(32'h1, {31'h0, irq_o}, "irq");
      wb(8'h20, 1'b1, 32'h2);
      chk(32'h0, {31'h0, irq_o}, "irq");
      rd(8'h24, 32'h3, "mask");
      i_lp.event_pulse(3'h6);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h24, 32'h0, "mask");
      rd(8'h18, 32'h0, "expansion");
      rd(8'h20, 32'h0, "status");
      i_lp.send(16'h0001);
      rd(8'h20, 32'h4, "status");
      $display("test flags done");
      end_sim;
   end
endmodule
bind autoneg_partner_status anps_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o),
   .ack_o(ack_o), .code_word_i(code_word_i), .code_word_valid_i(code_word_valid_i),
   .autoneg_restart_i(autoneg_restart_i), .parallel_fault_i(parallel_fault_i),
   .new_page_i(new_page_i), .irq_o(irq_o));
`default_nettype wire

// ===== include/anps_consts.vh
// constants for the auto-negotiation partner status register bank
`ifndef ANPS_CONSTS_VH
`define ANPS_CONSTS_VH

////////////////////////////////////////////////////////////////////////
// register indices (byte address = index * 4)
`define ANPS_IDX_PARTNER   6'h05
`define ANPS_IDX_EXPANSION 6'h06
`define ANPS_IDX_IRQ_STAT  6'h08
`define ANPS_IDX_IRQ_MASK  6'h09

////////////////////////////////////////////////////////////////////////
// link_partner_ability field positions
`define LPA_NEXT_PAGE      15
`define LPA_ACK            14
`define LPA_REMOTE_FAULT   13
`define LPA_RSVD_HI        12
`define LPA_RSVD_LO        11
`define LPA_PAUSE          10
`define LPA_FOUR_PAIR_100  9
`define LPA_FAST_FULL      8
`define LPA_FAST_HALF      7
`define LPA_TEN_FULL       6
`define LPA_TEN_HALF       5
`define LPA_SEL_HI         4
`define LPA_SEL_LO         0

////////////////////////////////////////////////////////////////////////
// autoneg_expansion field positions
`define AXP_PARALLEL_FAULT 4
`define AXP_PARTNER_NP     3
`define AXP_LOCAL_NP       2
`define AXP_PAGE_RX        1
`define AXP_PARTNER_AN     0

////////////////////////////////////////////////////////////////////////
// interrupt status / mask bit positions
`define IRQ_PARALLEL_FAULT 0
`define IRQ_PAGE_RX        1
`define IRQ_WORD_RX        2
`define IRQ_WIDTH          3

////////////////////////////////////////////////////////////////////////
// widths and reset values
`define LH_WIDTH           2
`define REG_WIDTH          16
`define RST_PARTNER        16'h0000
`define RST_EXPANSION      16'h0000
`define RST_IRQ            3'h0
`define RST_LH             2'h0
`define LOCAL_NP_VALUE     1'h0
`define BUS_DATA_ZERO      32'h0000_0000

`endif

// ===== logic/autoneg_partner_status.v
// partner ability and expansion status registers on classic wishbone
//
// Decided for this implementation: the Wishbone slave port.
`include "anps_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module autoneg_partner_status
(
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [31:0] dat_i,
   input  wire [3:0]  sel_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   // auto-negotiation receiver side
   input  wire [15:0] code_word_i,
   input  wire        code_word_valid_i,
   input  wire        autoneg_restart_i,
   input  wire        parallel_fault_i,
   input  wire        new_page_i,
   // interrupt
   output wire        irq_o
);

   ////////////////////////////////////////////////////////////////////
   // declarations
   wire [5:0]             reg_index;
   wire                   bus_req;
   wire                   bus_take;
   wire                   bus_rd;
   wire                   bus_wr;
   wire                   hit_partner;
   wire                   hit_expansion;
   wire                   hit_irq_stat;
   wire                   hit_irq_mask;
   wire                   hit_any;
   wire [15:0]            held_word;
   wire                   word_seen;
   wire [`LH_WIDTH-1:0]   lh_set;
   wire [`LH_WIDTH-1:0]   lh_clr;
   wire [`LH_WIDTH-1:0]   lh_flag;
   wire [`IRQ_WIDTH-1:0]  irq_set;
   wire [`IRQ_WIDTH-1:0]  irq_clr;
   wire [`IRQ_WIDTH-1:0]  irq_stat;
   reg  [`IRQ_WIDTH-1:0]  irq_mask;
   reg  [`REG_WIDTH-1:0]  partner_view;
   reg  [`REG_WIDTH-1:0]  expansion_view;
   reg  [31:0]            next_dat;

   ////////////////////////////////////////////////////////////////////
   // bus decode: word index from byte address
   assign reg_index = adr_i[7:2];
   assign bus_req   = cyc_i & stb_i;

   // a request is served once, in the cycle before ack rises
   assign bus_take  = bus_req & ~ack_o;
   assign bus_rd    = bus_take & ~we_i;
   assign bus_wr    = bus_take & we_i;

   // register hits
   assign hit_partner   = (reg_index == `ANPS_IDX_PARTNER);
   assign hit_expansion = (reg_index == `ANPS_IDX_EXPANSION);
   assign hit_irq_stat  = (reg_index == `ANPS_IDX_IRQ_STAT);
   assign hit_irq_mask  = (reg_index == `ANPS_IDX_IRQ_MASK);
   assign hit_any       = hit_partner | hit_expansion
                        | hit_irq_stat | hit_irq_mask;

   ////////////////////////////////////////////////////////////////////
   // partner ability word, captured from received link code words
   code_word_capture u_capture
   (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .restart_i    (autoneg_restart_i),
      .word_valid_i (code_word_valid_i),
      .word_i       (code_word_i),
      .ability_o    (held_word),
      .seen_o       (word_seen)
   );

   ////////////////////////////////////////////////////////////////////
   // partner ability read view; bus writes never reach it
   always @*
   begin
      partner_view = `RST_PARTNER;
      partner_view[`LPA_NEXT_PAGE]     = held_word[`LPA_NEXT_PAGE];
      partner_view[`LPA_ACK]           = held_word[`LPA_ACK];
      partner_view[`LPA_REMOTE_FAULT]  = held_word[`LPA_REMOTE_FAULT];
      partner_view[`LPA_PAUSE]         = held_word[`LPA_PAUSE];
      partner_view[`LPA_FOUR_PAIR_100] = held_word[`LPA_FOUR_PAIR_100];
      partner_view[`LPA_FAST_FULL]     = held_word[`LPA_FAST_FULL];
      partner_view[`LPA_FAST_HALF]     = held_word[`LPA_FAST_HALF];
      partner_view[`LPA_TEN_FULL]      = held_word[`LPA_TEN_FULL];
      partner_view[`LPA_TEN_HALF]      = held_word[`LPA_TEN_HALF];
      partner_view[`LPA_SEL_HI:`LPA_SEL_LO] =
         held_word[`LPA_SEL_HI:`LPA_SEL_LO];
      // reserved 12:11 stay zero
      partner_view[`LPA_RSVD_HI:`LPA_RSVD_LO] = 2'h0;
   end

   ////////////////////////////////////////////////////////////////////
   // latched-high expansion flags: bit 0 parallel fault, bit 1 page rx
   assign lh_set[0] = parallel_fault_i;
   assign lh_set[1] = new_page_i;

   // reading the expansion register clears both latched flags
   assign lh_clr    = {`LH_WIDTH{bus_rd & hit_expansion}};

   sticky_flags
   #(
      .WIDTH (`LH_WIDTH)
   )
   u_latch_high_sticky
   (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (lh_set),
      .clr_i  (lh_clr),
      .flag_o (lh_flag)
   );

   ////////////////////////////////////////////////////////////////////
   // expansion read view
   always @*
   begin
      expansion_view = `RST_EXPANSION;
      expansion_view[`AXP_PARALLEL_FAULT] = lh_flag[0];
      expansion_view[`AXP_PARTNER_NP]     = held_word[`LPA_NEXT_PAGE];
      expansion_view[`AXP_LOCAL_NP]       = `LOCAL_NP_VALUE;
      expansion_view[`AXP_PAGE_RX]        = lh_flag[1];
      expansion_view[`AXP_PARTNER_AN]     = word_seen;
      // 15:5 reserved, read as zero
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt status: events set, write one to clear
   assign irq_set[`IRQ_PARALLEL_FAULT] = parallel_fault_i;
   assign irq_set[`IRQ_PAGE_RX]        = new_page_i;
   assign irq_set[`IRQ_WORD_RX]        = code_word_valid_i;

   // clear only via byte lane 0 of a status write
   assign irq_clr = (bus_wr & hit_irq_stat & sel_i[0])
                  ? dat_i[`IRQ_WIDTH-1:0]
                  : `RST_IRQ;

   sticky_flags
   #(
      .WIDTH (`IRQ_WIDTH)
   )
   u_irq_status
   (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (irq_set),
      .clr_i  (irq_clr),
      .flag_o (irq_stat)
   );

   ////////////////////////////////////////////////////////////////////
   // interrupt mask register, same layout as status
   always @(posedge clk_i)
   begin
      if (rst_i)
         irq_mask <= `RST_IRQ;
      else if (bus_wr & hit_irq_mask & sel_i[0])
         irq_mask <= dat_i[`IRQ_WIDTH-1:0];
   end

   // level interrupt while any enabled status bit is set
   assign irq_o = |(irq_stat & irq_mask);

   ////////////////////////////////////////////////////////////////////
   // read data select; unmapped and write cycles return zero
   always @*
   begin
      next_dat = `BUS_DATA_ZERO;
      if (bus_rd)
      begin
         case (1'b1)
            hit_partner:
               next_dat[`REG_WIDTH-1:0] = partner_view;
            hit_expansion:
               next_dat[`REG_WIDTH-1:0] = expansion_view;
            hit_irq_stat:
               next_dat[`IRQ_WIDTH-1:0] = irq_stat;
            hit_irq_mask:
               next_dat[`IRQ_WIDTH-1:0] = irq_mask;
            default:
               next_dat = `BUS_DATA_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // ack one cycle after the request, dropped the cycle after
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= `BUS_DATA_ZERO;
      end
      else
      begin
         ack_o <= bus_take;
         dat_o <= next_dat;
      end
   end

   // writes to the two status registers fall through here untouched
   // so the captured partner fields cannot be disturbed by software

endmodule

`default_nettype wire

// ===== logic/code_word_capture.v
// holder for the partner's last base link code word
`include "anps_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module code_word_capture
(
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        restart_i,
   input  wire        word_valid_i,
   input  wire [15:0] word_i,
   output reg  [15:0] ability_o,
   output reg         seen_o
);

   ////////////////////////////////////////////////////////////////////
   // a received word or a restart changes the held fields; a word wins
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ability_o <= `RST_PARTNER;
         seen_o    <= 1'b0;
      end
      else if (word_valid_i)
      begin
         ability_o <= word_i;
         seen_o    <= 1'b1;
      end
      else if (restart_i)
      begin
         ability_o <= `RST_PARTNER;
         seen_o    <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ===== logic/sticky_flags.v
// row of sticky flags: set wins over clear
`timescale 1ns/1ps
`default_nettype none

module sticky_flags
#(
   parameter WIDTH = 2
)
(
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire [WIDTH-1:0] set_i,
   input  wire [WIDTH-1:0] clr_i,
   output wire [WIDTH-1:0] flag_o
);

   reg [WIDTH-1:0] flag;

   genvar g;
   ////////////////////////////////////////////////////////////////////
   // one flop per flag; an event in the clear cycle is kept
   generate
      for (g = 0; g < WIDTH; g = g + 1)
      begin : bit_g
         always @(posedge clk_i)
         begin
            if (rst_i)
               flag[g] <= 1'b0;
            else if (set_i[g])
               flag[g] <= 1'b1;
            else if (clr_i[g])
               flag[g] <= 1'b0;
         end
      end
   endgenerate

   assign flag_o = flag;

endmodule

`default_nettype wire
